// ===== verilog/bucket_pkg.sv
// constants shared by the activity monitor leaky-bucket files
package bucket_pkg;
	// ==========================================================
	// timing
	localparam int unsigned CLK_HZ         = 20_000_000;
	localparam int unsigned CYCLE_MS       = 128;
	localparam int unsigned CYCLE_CLKS     = (CLK_HZ / 1000) * CYCLE_MS;
	// ==========================================================
	// register indices; byte address is four times the index
	localparam logic [9:0]  IDX_SIZE       = 10'h056;
	localparam logic [9:0]  IDX_DECAY      = 10'h057;
	localparam logic [9:0]  IDX_UPPER      = 10'h060;
	localparam logic [9:0]  IDX_LOWER      = 10'h061;
	localparam logic [9:0]  IDX_STATUS     = 10'h062;
	localparam logic [9:0]  IDX_MASK       = 10'h063;
	localparam logic [9:0]  IDX_ALARM      = 10'h064;
	localparam logic [9:0]  IDX_ACC        = 10'h065;
	localparam logic [9:0]  IDX_ACC_SEL    = 10'h066;
	// ==========================================================
	// reset values and fields
	localparam logic [7:0]  RST_SIZE       = 8'h08;
	localparam logic [7:0]  RST_DECAY      = 8'h01;
	localparam logic [7:0]  RST_UPPER      = 8'h06;
	localparam logic [7:0]  RST_LOWER      = 8'h04;
	localparam int unsigned DECAY_LSB      = 0;
	localparam int unsigned DECAY_W        = 2;
	localparam int unsigned CLEAR_EV_LSB   = 16;
	// ==========================================================
	// bus responses
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage : bucket_pkg

// ===== verilog/cycle_timebase.sv
// divider that marks the end of each monitoring cycle with a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
module cycle_timebase #(
	parameter int unsigned PERIOD = 2560000
) (
	input  wire logic clk,     // system clock
	input  wire logic sys_rst, // synchronous reset, active high
	output logic      tick     // one-cycle pulse per period
);
	typedef struct packed {
		logic [31:0] cnt;
		logic        tick;
	} tb_state_t;

	tb_state_t st;
	tb_state_t next_st;

	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (st.cnt == 32'(PERIOD - 1)) begin
			next_st.cnt = 32'h0;
			next_st.tick = 1'b1;
		end else begin
			next_st.cnt = st.cnt + 32'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick = st.tick;
endmodule : cycle_timebase
`default_nettype wire

// ===== verilog/activity_bucket.sv
// leaky-bucket activity monitor with axi4-lite register slave
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Each input is judged once per 128 ms cycle, bad if it failed or was erratic at any time.
// - A bad cycle adds one to that input's accumulator, until the accumulator reaches the size register.
// - Each unbroken run of clean cycles as long as the decay period takes one away.
// - The two-bit decay field picks 128, 256, 512 or 1024 ms; bits 7:2 are unused.
// - The alarm rises when the accumulator reaches the upper threshold.
// - A raised alarm clears when the accumulator decays to the lower threshold.
module activity_bucket
	import bucket_pkg::*;
#(
	parameter int unsigned N_INPUTS   = 4,
	parameter int unsigned CYCLE_TICK = CYCLE_CLKS
) (
	input  wire logic                clk,           // system clock, 20 MHz
	input  wire logic                sys_rst,       // synchronous reset, active high
	input  wire logic [N_INPUTS-1:0] input_bad,     // input failed or erratic this clock
	output logic      [N_INPUTS-1:0] alarm,         // inactivity alarm per input
	output logic                     irq,           // level interrupt
	input  wire logic [31:0]         s_axi_awaddr,  // write address
	input  wire logic                s_axi_awvalid, // write address valid
	output logic                     s_axi_awready, // write address ready
	input  wire logic [31:0]         s_axi_wdata,   // write data
	input  wire logic [3:0]          s_axi_wstrb,   // write strobes
	input  wire logic                s_axi_wvalid,  // write data valid
	output logic                     s_axi_wready,  // write data ready
	output logic [1:0]               s_axi_bresp,   // write response
	output logic                     s_axi_bvalid,  // write response valid
	input  wire logic                s_axi_bready,  // write response ready
	input  wire logic [31:0]         s_axi_araddr,  // read address
	input  wire logic                s_axi_arvalid, // read address valid
	output logic                     s_axi_arready, // read address ready
	output logic [31:0]              s_axi_rdata,   // read data
	output logic [1:0]               s_axi_rresp,   // read response
	output logic                     s_axi_rvalid,  // read data valid
	input  wire logic                s_axi_rready   // read data ready
);
	typedef struct packed {
		logic [7:0]                size;
		logic [7:0]                decay;
		logic [7:0]                upper;
		logic [7:0]                lower;
		logic [31:0]               status;
		logic [31:0]               mask;
		logic [7:0]                acc_sel;
		logic [N_INPUTS-1:0][7:0]  acc;
		logic [N_INPUTS-1:0][2:0]  run;
		logic [N_INPUTS-1:0]       seen_bad;
		logic [N_INPUTS-1:0]       alarm;
		logic                      irq;
		logic                      aw_full;
		logic [9:0]                aw_idx;
		logic                      w_full;
		logic [31:0]               wdata;
		logic [3:0]                wstrb;
		logic                      awready;
		logic                      wready;
		logic                      bvalid;
		logic [1:0]                bresp;
		logic                      arready;
		logic                      rvalid;
		logic [31:0]               rdata;
		logic [1:0]                rresp;
	} mon_state_t;

	mon_state_t st;
	mon_state_t next_st;
	logic       cycle_end;

	// ==========================================================
	// monitoring cycle timebase
	cycle_timebase #(
		.PERIOD (CYCLE_TICK)
	) u_timebase (
		.clk     (clk),
		.sys_rst (sys_rst),
		.tick    (cycle_end)
	);

	// ==========================================================
	// register decode helpers
	function automatic logic mapped(input logic [9:0] idx);
		mapped = (idx == IDX_SIZE) || (idx == IDX_DECAY) || (idx == IDX_UPPER) ||
			(idx == IDX_LOWER) || (idx == IDX_STATUS) || (idx == IDX_MASK) ||
			(idx == IDX_ALARM) || (idx == IDX_ACC) || (idx == IDX_ACC_SEL);
	endfunction : mapped

	// ==========================================================
	// next-state logic
	always_comb begin
		logic                bad;
		logic [2:0]          period_m1;
		logic [31:0]         ev_set;
		logic [31:0]         ev_clr;
		logic [9:0]          ar_idx;
		logic [7:0]          acc_new;
		logic                do_write;
		bad       = 1'b0;
		period_m1 = 3'h0;
		ev_set    = 32'h0;
		ev_clr    = 32'h0;
		ar_idx    = s_axi_araddr[11:2];
		acc_new   = 8'h0;
		do_write  = 1'b0;
		next_st   = st;

		// decay period in cycles minus one: 0, 1, 3 or 7
		period_m1 = 3'((4'h1 << st.decay[DECAY_LSB +: DECAY_W]) - 4'h1);

		for (int i = 0; i < N_INPUTS; i++) begin
			next_st.seen_bad[i] = st.seen_bad[i] | input_bad[i];
			if (cycle_end) begin
				// a failure in the closing clock still counts for this cycle
				bad = st.seen_bad[i] | input_bad[i];
				next_st.seen_bad[i] = 1'b0;
				acc_new = st.acc[i];
				if (bad) begin
					next_st.run[i] = 3'h0;
					if (st.acc[i] < st.size) begin
						acc_new = st.acc[i] + 8'h1;
					end
				end else if (st.run[i] >= period_m1) begin
					// a run already past a newly shortened period drains at once
					next_st.run[i] = 3'h0;
					if (st.acc[i] != 8'h0) begin
						acc_new = st.acc[i] - 8'h1;
					end
				end else begin
					next_st.run[i] = st.run[i] + 3'h1;
				end
				next_st.acc[i] = acc_new;
				if (!st.alarm[i] && acc_new >= st.upper) begin
					next_st.alarm[i] = 1'b1;
					ev_set[i] = 1'b1;
				end else if (st.alarm[i] && acc_new <= st.lower) begin
					next_st.alarm[i] = 1'b0;
					ev_set[CLEAR_EV_LSB + i] = 1'b1;
				end
			end
		end

		// ------------------------------------------------------
		// write channel: address and data taken in either order
		if (s_axi_awvalid && st.awready) begin
			next_st.aw_full = 1'b1;
			next_st.aw_idx  = s_axi_awaddr[11:2];
		end
		if (s_axi_wvalid && st.wready) begin
			next_st.w_full = 1'b1;
			next_st.wdata  = s_axi_wdata;
			next_st.wstrb  = s_axi_wstrb;
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		do_write = st.aw_full && st.w_full && !st.bvalid;
		if (do_write) begin
			next_st.aw_full = 1'b0;
			next_st.w_full  = 1'b0;
			next_st.bvalid  = 1'b1;
			next_st.bresp   = mapped(st.aw_idx) ? RESP_OKAY : RESP_SLVERR;
			if (st.wstrb[0]) begin
				unique case (st.aw_idx)
					IDX_SIZE:    next_st.size    = st.wdata[7:0];
					IDX_DECAY:   next_st.decay   = st.wdata[7:0];
					IDX_UPPER:   next_st.upper   = st.wdata[7:0];
					IDX_LOWER:   next_st.lower   = st.wdata[7:0];
					IDX_MASK:    next_st.mask    = st.wdata;
					IDX_ACC_SEL: next_st.acc_sel = st.wdata[7:0];
					default:     ;
				endcase
			end
		end
		next_st.awready = !next_st.aw_full && !next_st.bvalid;
		next_st.wready  = !next_st.w_full && !next_st.bvalid;

		// ------------------------------------------------------
		// read channel: one cycle from address to data
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (s_axi_arvalid && st.arready) begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
			next_st.rdata  = 32'h0;
			unique case (ar_idx)
				IDX_SIZE:    next_st.rdata[7:0] = st.size;
				IDX_DECAY:   next_st.rdata[7:0] = st.decay;
				IDX_UPPER:   next_st.rdata[7:0] = st.upper;
				IDX_LOWER:   next_st.rdata[7:0] = st.lower;
				IDX_STATUS: begin
					next_st.rdata = st.status;
					ev_clr = st.status;
				end
				IDX_MASK:    next_st.rdata = st.mask;
				IDX_ALARM:   next_st.rdata[N_INPUTS-1:0] = st.alarm;
				IDX_ACC: begin
					if (st.acc_sel < 8'(N_INPUTS)) begin
						next_st.rdata[7:0] = st.acc[st.acc_sel];
					end
				end
				IDX_ACC_SEL: next_st.rdata[7:0] = st.acc_sel;
				default:     ;
			endcase
		end
		next_st.arready = !next_st.rvalid;

		// a read clears only what it returned; a new event wins
		next_st.status = (st.status & ~ev_clr) | ev_set;
		next_st.irq    = |(next_st.status & st.mask);
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st         <= '0;
			st.size    <= RST_SIZE;
			st.decay   <= RST_DECAY;
			st.upper   <= RST_UPPER;
			st.lower   <= RST_LOWER;
			st.awready <= 1'b1;
			st.wready  <= 1'b1;
			st.arready <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign alarm         = st.alarm;
	assign irq           = st.irq;
	assign s_axi_awready = st.awready;
	assign s_axi_wready  = st.wready;
	assign s_axi_bresp   = st.bresp;
	assign s_axi_bvalid  = st.bvalid;
	assign s_axi_arready = st.arready;
	assign s_axi_rdata   = st.rdata;
	assign s_axi_rresp   = st.rresp;
	assign s_axi_rvalid  = st.rvalid;
endmodule : activity_bucket
`default_nettype wire

// ===== testbench/bucket_monitor.sv
// concurrent checks on the leaky-bucket monitor ports
`timescale 1ns/10ps
`default_nettype none
module bucket_monitor
	import bucket_pkg::*;
#(
	parameter int unsigned N_INPUTS   = 4,
	parameter int unsigned CYCLE_TICK = CYCLE_CLKS
) (
	input wire logic                clk,           // clock
	input wire logic                sys_rst,       // reset
	input wire logic [N_INPUTS-1:0] input_bad,     // bad per input
	input wire logic [N_INPUTS-1:0] alarm,         // alarm per input
	input wire logic                s_axi_awvalid, // aw valid
	input wire logic                s_axi_awready, // aw ready
	input wire logic                s_axi_wvalid,  // w valid
	input wire logic                s_axi_wready,  // w ready
	input wire logic [1:0]          s_axi_bresp,   // b response
	input wire logic                s_axi_bvalid,  // b valid
	input wire logic                s_axi_bready,  // b ready
	input wire logic                s_axi_arvalid, // ar valid
	input wire logic                s_axi_arready, // ar ready
	input wire logic [31:0]         s_axi_rdata,   // r data
	input wire logic                s_axi_rvalid,  // r valid
	input wire logic                s_axi_rready   // r ready
);
	// ==========================================================
	// cycle tracking
	logic [31:0]         cnt;
	logic [N_INPUTS-1:0] seen;
	logic [N_INPUTS-1:0] last_bad;
	logic                wrap;
	logic                tick;
	// the design registers its cycle pulse, so tick trails the counter wrap by one clock
	assign wrap = (cnt == 32'(CYCLE_TICK - 1));
	// verdict of the cycle that just ended, per input
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt      <= '0;
			tick     <= 1'b0;
			seen     <= '0;
			last_bad <= '0;
		end else begin
			cnt  <= wrap ? 32'h0 : cnt + 32'h1;
			tick <= wrap;
			seen <= tick ? '0 : (seen | input_bad);
			if (tick)
				last_bad <= seen | input_bad;
		end
	end
	// ==========================================================
	// properties
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	alarm_at_tick_a: assert property ($changed(alarm) |-> $past(tick))
		else $error("alarm moved away from a cycle boundary");
	alarm_rise_bad_a: assert property ((alarm & ~$past(alarm) & ~last_bad) == '0)
		else $error("alarm rose after a clean cycle");
	alarm_fall_clean_a: assert property ((~alarm & $past(alarm) & last_bad) == '0)
		else $error("alarm cleared after a bad cycle");
	write_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
		else $error("write response late");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read data late");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	ar_refused_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken during response");
endmodule : bucket_monitor
bind activity_bucket bucket_monitor #(.N_INPUTS(N_INPUTS), .CYCLE_TICK(CYCLE_TICK)) monitor (
	.clk           (clk),
	.sys_rst       (sys_rst),
	.input_bad     (input_bad),
	.alarm         (alarm),
	.s_axi_awvalid (s_axi_awvalid),
	.s_axi_awready (s_axi_awready),
	.s_axi_wvalid  (s_axi_wvalid),
	.s_axi_wready  (s_axi_wready),
	.s_axi_bresp   (s_axi_bresp),
	.s_axi_bvalid  (s_axi_bvalid),
	.s_axi_bready  (s_axi_bready),
	.s_axi_arvalid (s_axi_arvalid),
	.s_axi_arready (s_axi_arready),
	.s_axi_rdata   (s_axi_rdata),
	.s_axi_rvalid  (s_axi_rvalid),
	.s_axi_rready  (s_axi_rready)
);
`default_nettype wire

// ===== testbench/testbench.sv
// self-checking bench for the leaky-bucket monitor
`timescale 1ns/10ps
`default_nettype none
module testbench
	import bucket_pkg::*;
;
	localparam int unsigned P = 20;
	logic        clk;
	logic        sys_rst;
	logic [3:0]  input_bad;
	logic [3:0]  alarm;
	logic        irq;
	logic [31:0] s_axi_awaddr;
	logic        s_axi_awvalid;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_wvalid;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready;
	logic [31:0] s_axi_araddr;
	logic        s_axi_arvalid;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready;
	logic [1:0]  resp;
	int          miscompares = 0;
	int          total_checks = 0;
	int          cycles = 0;
	int          phase = 0;
	// short cycle so a run of many cycles stays brief
	activity_bucket #(.CYCLE_TICK(P)) dut (
		.clk           (clk),
		.sys_rst       (sys_rst),
		.input_bad     (input_bad),
		.alarm         (alarm),
		.irq           (irq),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready)
	);
	// ==========================================================
	// helpers
	task automatic end_of_test;
		if (miscompares == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [31:0] ad(input logic [9:0] i);
		return {20'h0, i, 2'b00};
	endfunction : ad
	task automatic wr(input logic [9:0] i, input logic [31:0] v);
		@(posedge clk);
		s_axi_awaddr  <= ad(i);
		s_axi_wdata   <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		fork
			begin
				do @(posedge clk); while (!s_axi_awready);
				s_axi_awvalid <= 1'b0;
			end
			begin
				do @(posedge clk); while (!s_axi_wready);
				s_axi_wvalid <= 1'b0;
			end
		join
		// late bready lets the response stand for a while
		do @(posedge clk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b1;
		@(posedge clk);
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, RESP_OKAY});
	endtask : wr
	task automatic rd(input logic [9:0] i, output logic [31:0] v);
		@(posedge clk);
		s_axi_araddr  <= ad(i);
		s_axi_arvalid <= 1'b1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b1;
		@(posedge clk);
		v    = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic chk_rd(input logic [9:0] i, input logic [31:0] e);
		logic [31:0] v;
		rd(i, v);
		chk(v, e);
	endtask : chk_rd
	// each count waits for an update edge, then stops mid-cycle so reads never straddle one
	task automatic cyc(input int n);
		repeat (n) begin
			do @(posedge clk); while (phase != 0);
		end
		do @(posedge clk); while (phase != 10);
	endtask : cyc
	// ==========================================================
	// clock, cycle phase and timeout
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		phase  <= (sys_rst || phase == P - 1) ? 0 : phase + 1;
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			miscompares++;
			end_of_test();
		end
	end
	// ==========================================================
	// tests
	initial begin
		logic [31:0] v;
		sys_rst   = 1'b1;
		input_bad = 4'h0;
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		chk_rd(IDX_SIZE, {24'h0, RST_SIZE});
		chk_rd(IDX_DECAY, {24'h0, RST_DECAY});
		chk_rd(IDX_UPPER, {24'h0, RST_UPPER});
		chk_rd(IDX_LOWER, {24'h0, RST_LOWER});
		chk_rd(IDX_STATUS, 32'h0);
		rd(10'h3ff, v);
		chk(v, 32'h0);
		chk({30'h0, resp}, {30'h0, RESP_SLVERR});
		wr(IDX_SIZE, 32'h3);
		wr(IDX_UPPER, 32'h2);
		wr(IDX_LOWER, 32'h1);
		wr(IDX_DECAY, 32'h0);
		wr(IDX_MASK, 32'h1);
		input_bad <= 4'h1;
		cyc(1);
		chk_rd(IDX_ACC, 32'h1);
		chk({28'h0, alarm}, 32'h0);
		cyc(1);
		chk({28'h0, alarm}, 32'h1);
		chk({31'h0, irq}, 32'h1);
		chk_rd(IDX_ALARM, 32'h1);
		chk_rd(IDX_STATUS, 32'h1);
		chk_rd(IDX_STATUS, 32'h0);
		chk({31'h0, irq}, 32'h0);
		cyc(3);
		chk_rd(IDX_ACC, 32'h3);
		// input 1 never failed, so its own bucket stays empty
		wr(IDX_ACC_SEL, 32'h1);
		chk_rd(IDX_ACC, 32'h0);
		wr(IDX_ACC_SEL, 32'h0);
		for (int d = 0; d < 4; d++) begin
			input_bad <= 4'h1;
			wr(IDX_DECAY, 32'(d));
			cyc(2);
			chk_rd(IDX_ACC, 32'h3);
			input_bad <= 4'h0;
			cyc(1 << d);
			chk_rd(IDX_ACC, 32'h3);
			cyc(1);
			chk_rd(IDX_ACC, 32'h2);
			chk({28'h0, alarm}, 32'h1);
		end
		cyc(1);
		wr(IDX_DECAY, 32'h0);
		cyc(4);
		chk_rd(IDX_ACC, 32'h0);
		chk({28'h0, alarm}, 32'h0);
		chk_rd(IDX_STATUS, 32'h10000);
		chk({31'h0, irq}, 32'h0);
		// a write without its low byte lane leaves the register alone
		s_axi_wstrb <= 4'he;
		wr(IDX_UPPER, 32'h7);
		s_axi_wstrb <= 4'hf;
		chk_rd(IDX_UPPER, 32'h2);
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
